// ===== src/tcc_regs.vh
// Register addresses, field positions, reset values and timing counts of the timer-1 channels
`ifndef TCC_REGS_VH
`define TCC_REGS_VH

// Mapped addresses (reached with register map select set)
`define TCC_ADDR_CC_ROW0     8'hD2
`define TCC_ADDR_CC_ROW1     8'hE2
`define TCC_ADDR_CC_ROW2     8'hF2
`define TCC_ADDR_CHAN_EN     8'hF6
`define TCC_ADDR_EDGE_SEL    8'hF7
// Unmapped addresses
`define TCC_ADDR_MATCH_FLAG  8'hBF
`define TCC_ADDR_PORT9       8'hF9
`define TCC_ADDR_PRIO_ONE    8'hB9
`define TCC_ADDR_SYS_CTRL    8'hB1

// Field positions
`define TCC_BIT_DIR_MAP      6
`define TCC_BIT_REG_MAP      4

// Reset values
`define TCC_RST_CHAN_EN      8'h00
`define TCC_RST_EDGE_SEL     8'h00
`define TCC_RST_MATCH_FLAG   8'h00
`define TCC_RST_PORT9        8'hFF
`define TCC_RST_PORT9_DIRECTION_REG         8'h00
`define TCC_RST_PRIO_ONE     8'h00
`define TCC_RST_SYS_CTRL     8'h00

// Timing: states per processor cycle, timer maximum
`define TCC_STATES_PER_CYCLE 6
`define TCC_TIMER_MAX        16'hFFFF

`endif

// ===== src/tcc_state_div.v
// Divider that makes the machine-state and processor-cycle enable pulses
`timescale 1ns/10ps
`include "tcc_regs.vh"
module tcc_state_div #(
  parameter CLKS_PER_STATE = 1            // Clock cycles in one machine state
) (
  input  wire ref_clk_i,                  // System clock
  input  wire rst_i,                      // Asynchronous reset, active high
  output wire state_en_o,                 // One pulse per machine state
  output wire cycle_en_o                  // One pulse per processor cycle
);

  reg  [7:0] clk_cnt;                     // Clocks within the current state
  reg  [2:0] state_cnt;                   // States within the current cycle
  wire       last_clk;                    // Last clock of a state

  assign last_clk   = (clk_cnt == CLKS_PER_STATE[7:0] - 8'h01);
  assign state_en_o = last_clk;
  // Timer 2 steps once per six states, the clock rate over six times CLKS_PER_STATE
  assign cycle_en_o = last_clk && (state_cnt == `TCC_STATES_PER_CYCLE - 3'h1);

  // State and cycle counters
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      clk_cnt   <= 8'h00;
      state_cnt <= 3'h0;
    end
    else if (last_clk)
    begin
      clk_cnt <= 8'h00;
      if (state_cnt == `TCC_STATES_PER_CYCLE - 3'h1)
        state_cnt <= 3'h0;
      else
        state_cnt <= state_cnt + 3'h1;
    end
    else
      clk_cnt <= clk_cnt + 8'h01;
  end

endmodule // tcc_state_div

// ===== src/tcc_t2_int.v
// Timer 2 with five compare mode 0 channels and their interrupt input switching
`timescale 1ns/10ps
`include "tcc_regs.vh"
module tcc_t2_int (
  input  wire        ref_clk_i,           // System clock
  input  wire        rst_i,               // Asynchronous reset, active high
  input  wire        cycle_en_i,          // Processor cycle pulse
  input  wire [15:0] t2_reload_i,         // Timer 2 reload value
  input  wire [79:0] t2_cmp_val_i,        // Compare values, channel 0 in low word
  input  wire [4:0]  t2_cmp_en_i,         // Compare output enable per port-1 pin
  input  wire [4:0]  p1_i,                // Port-1 pin levels 0 to 4
  input  wire        reload_channel_edge_sel_i, // Channel 0 edge: 1 rising, 0 falling
  input  wire        channel_four_edge_sel_i,   // Channel 4 edge: 1 rising, 0 falling
  output reg  [15:0] t2_count_o,          // Timer 2 count
  output reg  [4:0]  t2_cmp_out_o,        // Compare outputs
  output reg  [4:0]  ext_irq_set_o        // Pulse that sets an external interrupt flag
);

  wire [4:0] cmp_sig;                     // Internal compare signals
  wire [4:0] irq_in;                      // Interrupt logic inputs after switching
  reg  [4:0] irq_in_q;                    // Previous interrupt inputs
  reg        edge_armed;                  // Previous sample is real, no false edge after reset
  wire [4:0] rise_sel;                    // Per channel edge selection
  wire       wrap;                        // Timer at maximum on an increment
  genvar     g;

  assign wrap = cycle_en_i && (t2_count_o == `TCC_TIMER_MAX);
  // Channels 1 to 3 always fire on the active edge
  assign rise_sel = {channel_four_edge_sel_i, 3'b111, reload_channel_edge_sel_i};

  generate
    for (g = 0; g < 5; g = g + 1)
    begin : g_chan
      // Compare signal stays active while count equals register
      assign cmp_sig[g] = (t2_count_o == t2_cmp_val_i[16*g+15:16*g]);
      // Pin is cut off from the interrupt input in compare use
      assign irq_in[g]  = t2_cmp_en_i[g] ? cmp_sig[g] : p1_i[g];
    end
  endgenerate

  // Timer 2 counter with auto reload
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      t2_count_o <= 16'h0000;
    else if (wrap)
      t2_count_o <= t2_reload_i;
    else if (cycle_en_i)
      t2_count_o <= t2_count_o + 16'h0001;
  end

  // Compare mode 0 outputs: set on match, cleared on overflow
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      t2_cmp_out_o <= 5'h00;
    else
      // Half spikes at reload value and at maximum come from this pair
      t2_cmp_out_o <= ((t2_cmp_out_o | cmp_sig) & ~({5{wrap}})) & t2_cmp_en_i;
  end

  // Edge detect on the switched interrupt inputs
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      irq_in_q      <= 5'h00;
      edge_armed    <= 1'b0;
      ext_irq_set_o <= 5'h00;
    end
    else
    begin
      irq_in_q   <= irq_in;
      edge_armed <= 1'b1;                 // First sample after reset only primes the detector
      // Enabling compare with pin high gives a falling edge at once
      ext_irq_set_o <= {5{edge_armed}} & ((rise_sel & irq_in & ~irq_in_q) |
                       (~rise_sel & ~irq_in & irq_in_q));
    end
  end

endmodule // tcc_t2_int

// ===== src/tcc_top.v
// Compare/capture channels of compare timer 1 with register interface and timer 2 link
`timescale 1ns/10ps
`include "tcc_regs.vh"

// Behaviour
// - Timer-1 channels compare in compare mode 0
// - Direction 0 compare, direction 1 capture
// - Direction write needs direction map prefix
// - Capture latches sixteen-bit timer-1 count
// - Edge select bit: 0 falling, 1 rising
// - Edge select reachable only with map set
// - Capture pins sampled once every state
// - Capture event sets channel match flag
// - Timer-2 unreachable duty shows two half spikes
// - Compare equal reload gives constant high
// - Compare FFFF gives one-clock high pulse
// - Timer clock equals one state unprescaled
// - Timer 2 steps every six states
// - Compare use switches interrupt input internally
// - Compare signal updates output and flag
// - Compare signal active while count equals
// - Channel 0 and 4 edge selectable
// - Channels 1-3 interrupt on active edge
// - Enabling compare may set flag at once
// - Enable bit connects pin to channel
module tcc_top #(
  parameter CLKS_PER_STATE = 1            // Clock cycles in one machine state
) (
  input  wire        ref_clk_i,           // System clock
  input  wire        rst_i,               // Asynchronous reset, active high
  input  wire [7:0]  sfr_addr_i,          // Register address
  input  wire        sfr_wr_i,            // Write strobe
  input  wire        sfr_rd_i,            // Read strobe
  input  wire [7:0]  sfr_wdata_i,         // Write data
  output reg  [7:0]  sfr_rdata_o,         // Read data, valid the cycle after the strobe
  input  wire        instr_start_i,       // Pulse at the start of each instruction
  input  wire [15:0] ct1_count_i,         // Compare timer 1 count
  input  wire        ct1_tick_i,          // Compare timer 1 clock pulse
  input  wire [7:0]  p9_i,                // Port-9 pin levels
  output reg  [7:0]  p9_o,                // Port-9 pin drive levels
  output reg  [7:0]  p9_oe_o,             // Port-9 output enables
  output wire [7:0]  channel_match_flag_o, // Channel match flags
  input  wire [15:0] t2_reload_i,         // Timer 2 reload value
  input  wire [79:0] t2_cmp_val_i,        // Timer 2 compare values
  input  wire [4:0]  t2_cmp_en_i,         // Timer 2 compare enables on port-1
  input  wire [4:0]  p1_i,                // Port-1 pin levels
  input  wire        reload_channel_edge_sel_i, // Channel 0 edge select
  input  wire        channel_four_edge_sel_i,   // Channel 4 edge select
  output wire [15:0] t2_count_o,          // Timer 2 count
  output wire [4:0]  t2_cmp_out_o,        // Timer 2 compare outputs
  output wire [4:0]  ext_irq_set_o        // External interrupt flag set pulses
);

  reg  [15:0] timer1_channel_regs [0:7];  // Compare/capture values
  reg  [7:0]  channel_enable_reg;         // Pin to channel connection
  reg  [7:0]  capture_edge_select;        // 1 rising, 0 falling
  reg  [7:0]  channel_match_flag_reg;     // Sticky channel flags
  reg  [7:0]  port9_latch;                // Port-9 output latch
  reg  [7:0]  port9_direction_reg;        // 0 compare, 1 capture
  reg  [7:0]  priority_reg_one;           // Holds the direction map bit
  reg  [7:0]  system_control_reg;         // Holds the register map select bit
  reg         dir_arm;                    // Direction map bit just set
  reg         dir_win;                    // Current instruction may write direction
  reg  [7:0]  pin_smp;                    // Pin sample of this state
  reg  [7:0]  pin_smp_q;                  // Pin sample of the previous state
  reg  [7:0]  match_q;                    // Match state at the last timer tick
  wire [7:0]  cmp_out;                    // Compare outputs per channel
  wire [7:0]  match;                      // Count equals channel register
  wire [7:0]  cap_ev;                     // Capture events
  wire [7:0]  cmp_ev;                     // Compare match events
  wire        state_en;                   // Machine state pulse
  wire        cycle_en;                   // Processor cycle pulse
  wire        reg_map;                    // Mapped registers visible
  wire [4:0]  cc_dec;                     // Channel register decode
  wire        wr_dir;                     // Write goes to direction register
  integer     i;

  // Decode a channel byte address: {hit, index[2:0], high byte}
  function [4:0] cc_decode;
    input [7:0] a;
    reg   [7:0] off;
    begin
      off       = 8'h00;
      cc_decode = 5'h00;
      if (a >= `TCC_ADDR_CC_ROW0 && a < `TCC_ADDR_CC_ROW0 + 8'h06)
      begin
        off       = a - `TCC_ADDR_CC_ROW0;
        cc_decode = {1'b1, off[3:1], off[0]};
      end
      else if (a >= `TCC_ADDR_CC_ROW1 && a < `TCC_ADDR_CC_ROW1 + 8'h06)
      begin
        off       = a - `TCC_ADDR_CC_ROW1 + 8'h06;
        cc_decode = {1'b1, off[3:1], off[0]};
      end
      else if (a >= `TCC_ADDR_CC_ROW2 && a < `TCC_ADDR_CC_ROW2 + 8'h04)
      begin
        off       = a - `TCC_ADDR_CC_ROW2 + 8'h0C;
        cc_decode = {1'b1, off[3:1], off[0]};
      end
    end
  endfunction

  assign reg_map = system_control_reg[`TCC_BIT_REG_MAP];
  assign cc_dec  = cc_decode(sfr_addr_i);
  assign wr_dir  = sfr_wr_i && dir_win && (sfr_addr_i == `TCC_ADDR_PORT9);
  assign channel_match_flag_o = channel_match_flag_reg;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_ch
      // Count at or above the value: equal to reload holds high, FFFF gives one tick
      assign cmp_out[g] = (ct1_count_i >= timer1_channel_regs[g]);
      assign match[g]   = (ct1_count_i == timer1_channel_regs[g]);
    end
  endgenerate

  // Compare events only for enabled channels in compare direction
  assign cmp_ev = match & ~match_q & channel_enable_reg & ~port9_direction_reg;
  // Falling or rising edge between two state samples
  assign cap_ev = channel_enable_reg & port9_direction_reg &
                  ((capture_edge_select & pin_smp & ~pin_smp_q) |
                   (~capture_edge_select & ~pin_smp & pin_smp_q));

  // State and cycle enables
  tcc_state_div #(
    .CLKS_PER_STATE (CLKS_PER_STATE)
  ) u_div (
    .ref_clk_i  (ref_clk_i),
    .rst_i      (rst_i),
    .state_en_o (state_en),
    .cycle_en_o (cycle_en)
  );

  // Timer 2 compare channels and interrupt input switching
  tcc_t2_int u_t2 (
    .ref_clk_i                 (ref_clk_i),
    .rst_i                     (rst_i),
    .cycle_en_i                (cycle_en),
    .t2_reload_i               (t2_reload_i),
    .t2_cmp_val_i              (t2_cmp_val_i),
    .t2_cmp_en_i               (t2_cmp_en_i),
    .p1_i                      (p1_i),
    .reload_channel_edge_sel_i (reload_channel_edge_sel_i),
    .channel_four_edge_sel_i   (channel_four_edge_sel_i),
    .t2_count_o                (t2_count_o),
    .t2_cmp_out_o              (t2_cmp_out_o),
    .ext_irq_set_o             (ext_irq_set_o)
  );

  // Pin sampling once per machine state
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_smp   <= 8'h00;
      pin_smp_q <= 8'h00;
    end
    else if (state_en)
    begin
      pin_smp   <= p9_i;
      pin_smp_q <= pin_smp;
    end
  end

  // Match state taken at each compare timer clock, one state when unprescaled
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      match_q <= 8'h00;
    else if (ct1_tick_i)
      match_q <= match;
  end

  // Direction map prefix: opens a window for the following instruction only
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dir_arm <= 1'b0;
      dir_win <= 1'b0;
    end
    else
    begin
      if (sfr_wr_i && sfr_addr_i == `TCC_ADDR_PRIO_ONE && sfr_wdata_i[`TCC_BIT_DIR_MAP])
        dir_arm <= 1'b1;
      else if (instr_start_i)
        dir_arm <= 1'b0;
      if (instr_start_i)
        dir_win <= dir_arm;
    end
  end

  // Control register writes
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      channel_enable_reg  <= `TCC_RST_CHAN_EN;
      capture_edge_select <= `TCC_RST_EDGE_SEL;
      port9_latch         <= `TCC_RST_PORT9;
      port9_direction_reg <= `TCC_RST_PORT9_DIRECTION_REG;
      priority_reg_one    <= `TCC_RST_PRIO_ONE;
      system_control_reg  <= `TCC_RST_SYS_CTRL;
    end
    else if (sfr_wr_i)
    begin
      // Mapped registers only while map select is set
      if (reg_map && sfr_addr_i == `TCC_ADDR_CHAN_EN)
        channel_enable_reg <= sfr_wdata_i;
      if (reg_map && sfr_addr_i == `TCC_ADDR_EDGE_SEL)
        capture_edge_select <= sfr_wdata_i;
      if (wr_dir)
        port9_direction_reg <= sfr_wdata_i;
      else if (sfr_addr_i == `TCC_ADDR_PORT9)
        port9_latch <= sfr_wdata_i;
      if (sfr_addr_i == `TCC_ADDR_PRIO_ONE)
        priority_reg_one <= sfr_wdata_i;
      if (sfr_addr_i == `TCC_ADDR_SYS_CTRL)
        system_control_reg <= sfr_wdata_i;
    end
  end

  // Channel registers: capture takes priority over a byte write
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (i = 0; i < 8; i = i + 1)
        timer1_channel_regs[i] <= 16'h0000;
    end
    else
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        if (cap_ev[i])
          timer1_channel_regs[i] <= ct1_count_i;
        else if (sfr_wr_i && reg_map && cc_dec[4] && cc_dec[3:1] == i[2:0])
        begin
          if (cc_dec[0])
            timer1_channel_regs[i][15:8] <= sfr_wdata_i;
          else
            timer1_channel_regs[i][7:0] <= sfr_wdata_i;
        end
      end
    end
  end

  // Channel match flags: hardware sets, software clears, set wins
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      channel_match_flag_reg <= `TCC_RST_MATCH_FLAG;
    else if (sfr_wr_i && sfr_addr_i == `TCC_ADDR_MATCH_FLAG)
      channel_match_flag_reg <= sfr_wdata_i | cap_ev | cmp_ev;
    else
      channel_match_flag_reg <= channel_match_flag_reg | cap_ev | cmp_ev;
  end

  // Pin drive: channel when enabled, port latch otherwise
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      p9_o    <= 8'h00;
      p9_oe_o <= 8'h00;
    end
    else
    begin
      p9_o    <= (channel_enable_reg & cmp_out) | (~channel_enable_reg & port9_latch);
      p9_oe_o <= ~port9_direction_reg;
    end
  end

  // Register read mux
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      sfr_rdata_o <= 8'h00;
    else if (sfr_rd_i)
    begin
      if (reg_map && cc_dec[4])
        sfr_rdata_o <= cc_dec[0] ? timer1_channel_regs[cc_dec[3:1]][15:8]
                                 : timer1_channel_regs[cc_dec[3:1]][7:0];
      else if (reg_map && sfr_addr_i == `TCC_ADDR_CHAN_EN)
        sfr_rdata_o <= channel_enable_reg;
      else if (reg_map && sfr_addr_i == `TCC_ADDR_EDGE_SEL)
        sfr_rdata_o <= capture_edge_select;
      else if (sfr_addr_i == `TCC_ADDR_MATCH_FLAG)
        sfr_rdata_o <= channel_match_flag_reg;
      else if (sfr_addr_i == `TCC_ADDR_PORT9)
        sfr_rdata_o <= p9_i;
      else if (sfr_addr_i == `TCC_ADDR_PRIO_ONE)
        sfr_rdata_o <= priority_reg_one;
      else if (sfr_addr_i == `TCC_ADDR_SYS_CTRL)
        sfr_rdata_o <= system_control_reg;
      else
        sfr_rdata_o <= 8'h00;             // Unmapped reads as zero
    end
  end

endmodule // tcc_top

// ===== verif/tcc_properties.sv
// Port assertions for the timer-1 compare/capture block
`timescale 1ns/10ps
`include "tcc_regs.vh"
module tcc_properties (
  input wire        ref_clk_i,
  input wire        rst_i,
  input wire [7:0]  sfr_addr_i,
  input wire        sfr_wr_i,
  input wire        sfr_rd_i,
  input wire [7:0]  sfr_wdata_i,
  input wire [7:0]  sfr_rdata_o,
  input wire [7:0]  p9_i,
  input wire [7:0]  p9_oe_o,
  input wire [7:0]  channel_match_flag_o,
  input wire [79:0] t2_cmp_val_i,
  input wire [4:0]  t2_cmp_en_i,
  input wire [15:0] t2_count_o,
  input wire [4:0]  t2_cmp_out_o,
  input wire [4:0]  ext_irq_set_o
);
  reg        map_q;   // Map select mirror
  reg  [7:0] edge_q;  // Edge select mirror
  reg  [7:0] flag_q;  // Flags one cycle back
  wire       flag_wr = sfr_wr_i && sfr_addr_i == `TCC_ADDR_MATCH_FLAG;  // Flag register write
  wire       p9_wr   = sfr_wr_i && sfr_addr_i == `TCC_ADDR_PORT9;       // Port 9 address write
  wire [7:0] cap_new = channel_match_flag_o & ~flag_q & ~p9_oe_o;      // Fresh capture flags
  // Mirror the register state the properties depend on
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      map_q  <= 1'b0;
      edge_q <= 8'h00;
      flag_q <= 8'h00;
    end
    else
    begin
      if (sfr_wr_i && sfr_addr_i == `TCC_ADDR_SYS_CTRL)
        map_q <= sfr_wdata_i[`TCC_BIT_REG_MAP];
      if (sfr_wr_i && map_q && sfr_addr_i == `TCC_ADDR_EDGE_SEL)
        edge_q <= sfr_wdata_i;
      flag_q <= channel_match_flag_o;
    end
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  AST_FLAG_SW_ONLY: assert property (|(flag_q & ~channel_match_flag_o) |-> $past(flag_wr))
    else $error("match flag cleared without a write");
  AST_EDGE_HIDDEN: assert property (sfr_rd_i && sfr_addr_i == `TCC_ADDR_EDGE_SEL && !map_q
    |=> sfr_rdata_o == 8'h00) else $error("edge select visible with map clear");
  AST_EDGE_READ: assert property (sfr_rd_i && sfr_addr_i == `TCC_ADDR_EDGE_SEL && map_q
    |=> sfr_rdata_o == $past(edge_q)) else $error("edge select read back wrong");
  AST_T2_STEP: assert property ($changed(t2_count_o) |=> $stable(t2_count_o) [*5])
    else $error("timer 2 stepped early");
  AST_T2_IRQ1: assert property (t2_cmp_en_i[1] && $past(t2_cmp_en_i[1]) && t2_count_o == t2_cmp_val_i[31:16]
    && $past(t2_count_o) != t2_cmp_val_i[31:16] |-> ##[0:2] ext_irq_set_o[1]) else $error("no channel 1 request");
  AST_T2_OUT2: assert property (t2_cmp_en_i[2] && t2_count_o == t2_cmp_val_i[47:32]
    |-> ##[0:2] t2_cmp_out_o[2]) else $error("channel 2 output not set on match");
  AST_DIR_BY_WRITE: assert property (!$past(rst_i) && !$past(rst_i, 2) && $changed(p9_oe_o)
    |-> $past(p9_wr) || $past(p9_wr, 2) || $past(p9_wr, 3)) else $error("direction changed unprompted");
  AST_CAP_EDGE: assert property (|cap_new && !$past(flag_wr)
    |-> |(cap_new & ($past(p9_i, 1) ^ $past(p9_i, 6)))) else $error("capture without a pin edge");
  AST_CAP_DIR: assert property (|cap_new && !$past(flag_wr)
    |-> (cap_new & (edge_q ^ $past(p9_i, 1))) == 8'h00) else $error("capture on the wrong edge");
  COV_CAPTURE: cover property (|cap_new);
  COV_CH4_IRQ: cover property (ext_irq_set_o[4]);
  COV_T2_OUT: cover property (t2_cmp_out_o[1]);
endmodule // tcc_properties

bind tcc_top tcc_properties prop_u (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
  .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .p9_i(p9_i),
  .p9_oe_o(p9_oe_o), .channel_match_flag_o(channel_match_flag_o), .t2_cmp_val_i(t2_cmp_val_i),
  .t2_cmp_en_i(t2_cmp_en_i), .t2_count_o(t2_count_o), .t2_cmp_out_o(t2_cmp_out_o),
  .ext_irq_set_o(ext_irq_set_o)
);

// ===== verif/tcc_pin_model.sv
// Port-9 pin model: outside drivers that yield to the block's own drive
`timescale 1ns/10ps
module tcc_pin_model (
  input  wire [7:0] p9_drv_i,  // Block drive levels
  input  wire [7:0] p9_oe_i,   // Block drive enables
  input  wire [7:0] ext_lvl_i, // Outside levels, held for many states per change
  output wire [7:0] pin_o      // Resolved pin levels
);
  // Driven pins follow the block, the rest show the steady outside level
  assign pin_o = (p9_oe_i & p9_drv_i) | (~p9_oe_i & ext_lvl_i);
endmodule // tcc_pin_model

// ===== verif/tcc_top_tb.sv
// Self-checking bench for the timer-1 compare/capture block
`timescale 1ns/10ps
`include "tcc_regs.vh"
module tcc_top_tb;
  reg         ref_clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg  [7:0]  sfr_addr_i = 8'h00;
  reg         sfr_wr_i = 1'b0;
  reg         sfr_rd_i = 1'b0;
  reg  [7:0]  sfr_wdata_i = 8'h00;
  reg         instr_start_i = 1'b0;
  reg  [15:0] ct1_count_i = 16'h0000;
  reg         ct1_tick_i = 1'b0;
  reg  [7:0]  ext_lvl = 8'h00;     // Outside pin levels
  reg  [4:0]  t2_cmp_en_i = 5'h0F; // Pin 4 starts as plain input
  reg  [4:0]  p1_i = 5'h10;        // Pin 4 high
  reg         ch4_rise = 1'b0;     // Channel 4 edge select, 1 rising
  wire [7:0]  sfr_rdata_o, p9_i, p9_o, p9_oe_o, channel_match_flag_o;
  wire [15:0] t2_count_o;
  wire [4:0]  t2_cmp_out_o, ext_irq_set_o;
  integer     fail_count = 0;
  integer     n_checks = 0;
  integer     cycles = 0;
  integer     irq1_n = 0;          // Channel 1 requests
  integer     irq4_n = 0;          // Channel 4 requests
  tcc_top dut_u (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .instr_start_i(instr_start_i), .ct1_count_i(ct1_count_i), .ct1_tick_i(ct1_tick_i),
    .p9_i(p9_i), .p9_o(p9_o), .p9_oe_o(p9_oe_o), .channel_match_flag_o(channel_match_flag_o),
    .t2_reload_i(16'hFF00), .t2_cmp_val_i({16'h0006, 16'h0005, 16'h0004, 16'h0003, 16'h0002}),
    .t2_cmp_en_i(t2_cmp_en_i), .p1_i(p1_i), .reload_channel_edge_sel_i(1'b0),
    .channel_four_edge_sel_i(ch4_rise), .t2_count_o(t2_count_o), .t2_cmp_out_o(t2_cmp_out_o),
    .ext_irq_set_o(ext_irq_set_o)
  );
  tcc_pin_model pin_u (.p9_drv_i(p9_o), .p9_oe_i(p9_oe_o), .ext_lvl_i(ext_lvl), .pin_o(p9_i));
  always #5 ref_clk_i = ~ref_clk_i;
  // Count request pulses and cut a hang short
  always @(posedge ref_clk_i)
  begin
    cycles = cycles + 1;
    if (ext_irq_set_o[1] === 1'b1)
      irq1_n = irq1_n + 1;
    if (ext_irq_set_o[4] === 1'b1)
      irq4_n = irq4_n + 1;
    if (cycles == 3000)
    begin
      fail_count = fail_count + 1;
      stop_test;
    end
  end
  // Compare one value and report a mismatch
  task check(input [15:0] got, input [15:0] exp);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  end
  endtask
  // Register write, taken at the second edge
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge ref_clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    sfr_wr_i <= 1'b0;
  end
  endtask
  // Register read and compare, data one cycle after the strobe
  task rd(input [7:0] a, input [7:0] exp);
  begin
    @(posedge ref_clk_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    sfr_rd_i <= 1'b0;
    #1;
    check(sfr_rdata_o, exp);
  end
  endtask
  // Instruction boundary pulse
  task instr;
  begin
    @(posedge ref_clk_i);
    instr_start_i <= 1'b1;
    @(posedge ref_clk_i);
    instr_start_i <= 1'b0;
  end
  endtask
  // New compare timer 1 count with one clock pulse
  task ct1(input [15:0] v);
  begin
    @(posedge ref_clk_i);
    ct1_count_i <= v;
    ct1_tick_i <= 1'b1;
    @(posedge ref_clk_i);
    ct1_tick_i <= 1'b0;
  end
  endtask
  // Let registered outputs settle
  task settle;
  begin
    repeat (8) @(posedge ref_clk_i);
    #1;
  end
  endtask
  // Print counts and verdict, then end
  task stop_test;
  begin
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  // Main sequence
  initial
  begin
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    settle;
    check(p9_oe_o, 8'hFF);
    check(channel_match_flag_o, `TCC_RST_MATCH_FLAG);
    wr(`TCC_ADDR_EDGE_SEL, 8'hFF);
    rd(`TCC_ADDR_EDGE_SEL, 8'h00);
    wr(`TCC_ADDR_SYS_CTRL, 8'h10);
    rd(`TCC_ADDR_EDGE_SEL, `TCC_RST_EDGE_SEL);
    wr(`TCC_ADDR_EDGE_SEL, 8'h08);
    rd(`TCC_ADDR_EDGE_SEL, 8'h08);
    rd(8'h55, 8'h00);
    wr(`TCC_ADDR_PORT9, 8'h00);
    settle;
    check(p9_oe_o, 8'hFF);
    check(p9_o, 8'h00);
    wr(`TCC_ADDR_PRIO_ONE, 8'h40);
    instr;
    wr(`TCC_ADDR_PORT9, 8'h0C);
    instr;
    wr(`TCC_ADDR_PRIO_ONE, 8'h00);
    settle;
    check(p9_oe_o, 8'hF3);
    ct1(16'h00FF);
    wr(8'hD4, 8'h00);
    wr(8'hD5, 8'h01);
    wr(`TCC_ADDR_CHAN_EN, 8'h0E);
    settle;
    check(p9_o[1], 1'b0);
    ct1(16'h0100);
    settle;
    check(p9_o[1], 1'b1);
    check(channel_match_flag_o, 8'h02);
    ct1(16'h5A3C);
    @(posedge ref_clk_i);
    ext_lvl[2] <= 1'b1;
    settle;
    check(channel_match_flag_o, 8'h02);
    @(posedge ref_clk_i);
    ext_lvl[2] <= 1'b0;
    settle;
    check(channel_match_flag_o, 8'h06);
    rd(8'hD6, 8'h3C);
    rd(8'hD7, 8'h5A);
    ct1(16'h1234);
    @(posedge ref_clk_i);
    ext_lvl[3] <= 1'b1;
    settle;
    rd(`TCC_ADDR_MATCH_FLAG, 8'h0E);
    rd(8'hE2, 8'h34);
    rd(8'hE3, 8'h12);
    wr(`TCC_ADDR_MATCH_FLAG, 8'h00);
    settle;
    check(channel_match_flag_o, 8'h00);
    check(t2_cmp_out_o, 5'h0F);
    check(irq1_n, 1);
    @(posedge ref_clk_i);
    t2_cmp_en_i <= 5'h1F;
    settle;
    check(irq4_n, 1);
    irq4_n = 0; // Drop the request raised by enabling compare
    @(posedge ref_clk_i);
    p1_i <= 5'h00;
    settle;
    check(irq4_n, 0);
    @(posedge ref_clk_i);
    t2_cmp_en_i <= 5'h0F;
    ch4_rise <= 1'b1;
    @(posedge ref_clk_i);
    p1_i <= 5'h10;
    settle;
    check(irq4_n, 1);
    stop_test;
  end
endmodule // tcc_top_tb
